// ---- mcw_defs.svh ----
/*
 * Constants of the motor configuration word bank: word addresses, word
 * and check widths, scaling figures and sequencing counts.
 * Assumes it is included by the package and the bank module only.
 */
// Overview of operation
// - Align current threshold is six-bit count, 0.086 A each.
// - Shunt resistance in milliohm is sense field divided by 37.
// - Rated voltage in volts is rated field divided by five.
// - Sleep inhibit bit set means standby is never entered.
// - Motor stops below selected off threshold, after curve when enabled.
// - Nudge start amplitude percent is field times 3.2 plus 2.4.
// - Short detect level bit selects 1 V or 2 V.
// - Lock restart wait bit selects 5 or 10 seconds.
// - Stall retry limit code: unlimited, 3, 5 or 10 attempts.
// - Brake mode zero brakes when current safe; one always brakes fully.
// - Clock ratio is 0.25 rpm/Hz per count; host keeps it below 42.
// - Curve enable bit passes demand through curve, else bypassed.
// - Two-way curve: 0 full reverse, 511 full forward, 255 stop.
// - Two-bit loop code: open loop, torque, speed, power.
// - Closed-loop setpoint is full scale times demand ratio.
// - Brake source bit picks register brake bit or brake pin.
// - Direction source bit picks host_dir input or direction pin; two-way curve sets direction itself.
// - Inductance is eight-bit field shifted left by three-bit shift.
// - Winding resistance field is phase to centre tap value.
// - Gains pack into two words as laid out.
// - Curve words hold corner input 17:9, output 8:0, no shadow.
// - Words hold 18 data bits plus six hidden check bits.
// - Reading a word address returns that word's contents.
`ifndef MCW_DEFS_SVH
`define MCW_DEFS_SVH

`define MCW_WORDS           64
`define MCW_DATA_W          18
`define MCW_ECC_W           6
`define MCW_FIRST_WORD      6'h12
`define MCW_LAST_SHADOW     6'h1f
`define MCW_CURVE_BASE      6'h20
`define MCW_CURVE_POINTS    32
`define MCW_SHADOW_OFS      8'h40
`define MCW_NUM_SHADOW      14

// Word addresses
`define MCW_GATE_ALIGN      6'h12
`define MCW_CAP_COMP        6'h13
`define MCW_SHUNT_RATED     6'h14
`define MCW_STANDBY_OFF     6'h15
`define MCW_PROT_BRAKE      6'h16
`define MCW_LOOP_SETPT      6'h17
`define MCW_WINDING_RES     6'h18
`define MCW_SRC_INDUCT      6'h19
`define MCW_TORQUE_CONST    6'h1a
`define MCW_GAP_A           6'h1b
`define MCW_PI_PRIMARY      6'h1c
`define MCW_PI_SECONDARY    6'h1d
`define MCW_GAP_B           6'h1e
`define MCW_OUT_TRIM        6'h1f

// Scaling figures
`define MCW_ALIGN_MA_PER_CNT  86
`define MCW_SHUNT_TENTH_NUM   10
`define MCW_SHUNT_TENTH_DEN   37
`define MCW_RATED_DIV         5
`define MCW_NUDGE_STEP        32
`define MCW_NUDGE_BASE        24
`define MCW_OFF_PM_00         97
`define MCW_OFF_PM_01         58
`define MCW_OFF_PM_10         128
`define MCW_OFF_PM_11         195
`define MCW_SHORT_LOW_MV      1000
`define MCW_SHORT_HIGH_MV     2000
`define MCW_LOCK_WAIT_SHORT_S 5
`define MCW_LOCK_WAIT_LONG_S  10
`define MCW_RETRY_01          3
`define MCW_RETRY_10          5
`define MCW_RETRY_11          10
`define MCW_CLK_RATIO_MAX     41
`define MCW_DEMAND_FULL       511
`define MCW_DEMAND_STOP       255

`endif

// ---- mcw_pkg.sv ----
/*
 * Types of the motor configuration word bank: the decoded configuration
 * and the run-time control results.
 * Assumes mcw_defs.svh sits in the include path.
 */
`include "mcw_defs.svh"

package mcw_pkg;

	typedef enum logic [1:0] {
		MCW_OPEN_LOOP,
		MCW_CONST_TORQUE,
		MCW_CONST_SPEED,
		MCW_CONST_POWER
	} mcw_loop_t;

	typedef struct packed {
		logic [1:0]  gate_slew;
		logic [12:0] align_current_ma;
		logic [3:0]  cap_comp_fall;
		logic [3:0]  cap_comp_rise;
		logic [7:0]  shunt_tenth_mohm;
		logic [8:0]  rated_tenth_v;
		logic        sleep_inhibit;
		logic [7:0]  nudge_start_amplitude;
		logic [10:0] short_detect_level;
		logic [3:0]  lock_wait_s;
		logic [3:0]  stall_retry_limit;
		logic        gentle_stop_long;
		logic [5:0]  clk_ratio;
		mcw_loop_t   loop_mode;
		logic [7:0]  winding_res;
		logic [14:0] inductance;
		logic [8:0]  torque_constant_value;
		logic [17:0] pi_primary;
		logic [5:0]  pi_secondary;
	} mcw_cfg_t;

	typedef struct packed {
		logic        brake_apply;
		logic        dir_fwd;
		logic        motor_stop;
		logic        standby_enter;
		logic [8:0]  curve_demand;
		logic [10:0] setpoint;
		logic        ratio_err;
	} mcw_ctrl_t;

endpackage : mcw_pkg

// ---- mcw_bank.sv ----
/*
 * Nonvolatile configuration word bank with shadow copies and the decode
 * of every field into the form the motor control logic consumes.
 * Assumes a host register port driven by the serial interface logic on
 * sys_clk, brake and direction pins arriving asynchronously, and run-time
 * demand and current status from logic on sys_clk.
 */
`timescale 1ns/1ns
`include "mcw_defs.svh"

module mcw_bank
	import mcw_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Host register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [23:0] reg_wdata,
	output logic      [23:0] reg_rdata,
	output logic             reg_rvalid,
	// Pins
	input  wire logic        brake_pin,
	input  wire logic        dir_pin,
	// Run-time inputs on sys_clk
	input  wire logic [8:0]  demand_in,
	input  wire logic        host_dir,
	input  wire logic        standby_req,
	input  wire logic        current_safe,
	// Results
	output mcw_cfg_t         cfg,
	output mcw_ctrl_t        ctrl,
	output logic             cfg_ready,
	output logic             ecc_err
);

	typedef enum logic {
		MCW_COPY,
		MCW_RUN
	} mcw_state_t;

	// Check bit k covers data bits whose position plus one has bit k set
	function automatic logic [`MCW_ECC_W-1:0] mcw_ecc(input logic [`MCW_DATA_W-1:0] d);
		logic [`MCW_ECC_W-1:0] c;
		logic [5:0]            p;
		c = '0;
		for (int i = 0; i < `MCW_DATA_W; i++) begin
			p = 6'(i + 1);
			for (int k = 0; k < `MCW_ECC_W; k++) begin
				c[k] = c[k] ^ (d[i] & p[k]);
			end
		end
		return c;
	endfunction : mcw_ecc

	// check bits kept above the data
	logic [23:0]            nv_ff     [`MCW_WORDS];
	logic [23:0]            nxt_nv    [`MCW_WORDS];
	logic [17:0]            shadow_ff [`MCW_NUM_SHADOW];
	logic [17:0]            nxt_shadow[`MCW_NUM_SHADOW];
	mcw_state_t             state_ff;
	mcw_state_t             nxt_state;
	logic [5:0]             copy_ff;
	logic [5:0]             nxt_copy;
	logic [23:0]            rdata_ff;
	logic [23:0]            nxt_rdata;
	logic                   rvalid_ff;
	logic                   nxt_rvalid;
	logic                   ecc_err_ff;
	logic                   nxt_ecc_err;
	logic [2:0]             brk_sync_ff;
	logic [2:0]             dir_sync_ff;
	logic                   brk_pin_ff;
	logic                   dir_pin_ff;
	logic                   nxt_brk_pin;
	logic                   nxt_dir_pin;
	mcw_cfg_t               cfg_ff;
	mcw_cfg_t               nxt_cfg;
	mcw_ctrl_t              ctrl_ff;
	mcw_ctrl_t              nxt_ctrl;

	logic                   word_hit;
	logic                   word_wr_ok;
	logic                   shad_hit;
	logic                   shad_wr_ok;
	logic [5:0]             word_idx;
	logic [3:0]             shad_idx;
	logic [7:0]             shad_ofs;

	assign word_idx = reg_addr[5:0];
	assign shad_ofs = reg_addr - `MCW_SHADOW_OFS;
	assign shad_idx = 4'(shad_ofs[5:0] - `MCW_FIRST_WORD);
	assign word_hit = (reg_addr < 8'(`MCW_WORDS)) && (word_idx >= `MCW_FIRST_WORD);
	assign shad_hit = (reg_addr >= (`MCW_SHADOW_OFS + 8'(`MCW_FIRST_WORD))) &&
		(reg_addr <= (`MCW_SHADOW_OFS + 8'(`MCW_LAST_SHADOW)));
	// The trim word is locked; the two unused word slots hold nothing
	assign word_wr_ok = word_hit && (word_idx != `MCW_OUT_TRIM) &&
		(word_idx != `MCW_GAP_A) && (word_idx != `MCW_GAP_B);
	assign shad_wr_ok = shad_hit && (shad_ofs[5:0] != `MCW_OUT_TRIM) &&
		(shad_ofs[5:0] != `MCW_GAP_A) && (shad_ofs[5:0] != `MCW_GAP_B);

	// Word store, shadows and copy walk
	always_comb begin
		nxt_nv     = nv_ff;
		nxt_shadow = shadow_ff;
		nxt_state  = state_ff;
		nxt_copy   = copy_ff;
		case (state_ff)
			MCW_COPY: begin
				nxt_shadow[4'(copy_ff - `MCW_FIRST_WORD)] = nv_ff[copy_ff][17:0];
				nxt_copy = copy_ff + 6'h01;
				if (copy_ff == `MCW_LAST_SHADOW) begin
					nxt_state = MCW_RUN;
				end
			end
			MCW_RUN: begin
				if (reg_wr && word_wr_ok) begin
					nxt_nv[word_idx] = {mcw_ecc(reg_wdata[17:0]), reg_wdata[17:0]};
				end
				if (reg_wr && shad_wr_ok) begin
					nxt_shadow[shad_idx] = reg_wdata[17:0];
				end
			end
			default: begin
				nxt_state = MCW_COPY;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `MCW_WORDS; i++) begin
				nv_ff[i] <= '0;
			end
			for (int i = 0; i < `MCW_NUM_SHADOW; i++) begin
				shadow_ff[i] <= '0;
			end
			state_ff <= MCW_COPY;
			copy_ff  <= `MCW_FIRST_WORD;
		end else begin
			nv_ff     <= nxt_nv;
			shadow_ff <= nxt_shadow;
			state_ff  <= nxt_state;
			copy_ff   <= nxt_copy;
		end
	end

	// Host reads, answered one cycle after the strobe
	always_comb begin
		nxt_rdata   = '0;
		nxt_rvalid  = reg_rd;
		nxt_ecc_err = ecc_err_ff;
		if (reg_rd && word_hit) begin
			nxt_rdata = {6'h00, nv_ff[word_idx][17:0]};
			if (mcw_ecc(nv_ff[word_idx][17:0]) != nv_ff[word_idx][23:18]) begin
				nxt_ecc_err = 1'b1;
			end
		end else if (reg_rd && shad_hit) begin
			nxt_rdata = {6'h00, shadow_ff[shad_idx]};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff   <= '0;
			rvalid_ff  <= 1'b0;
			ecc_err_ff <= 1'b0;
		end else begin
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
			ecc_err_ff <= nxt_ecc_err;
		end
	end

	// Pin synchronisers; a level counts once stages two and three agree
	always_comb begin
		nxt_brk_pin = brk_pin_ff;
		nxt_dir_pin = dir_pin_ff;
		if (brk_sync_ff[1] == brk_sync_ff[2]) begin
			nxt_brk_pin = brk_sync_ff[2];
		end
		if (dir_sync_ff[1] == dir_sync_ff[2]) begin
			nxt_dir_pin = dir_sync_ff[2];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			brk_sync_ff <= '0;
			dir_sync_ff <= '0;
			brk_pin_ff  <= 1'b0;
			dir_pin_ff  <= 1'b0;
		end else begin
			brk_sync_ff <= {brk_sync_ff[1:0], brake_pin};
			dir_sync_ff <= {dir_sync_ff[1:0], dir_pin};
			brk_pin_ff  <= nxt_brk_pin;
			dir_pin_ff  <= nxt_dir_pin;
		end
	end

	// Field decode from shadows
	logic [17:0] w_gate;
	logic [17:0] w_cap;
	logic [17:0] w_shunt;
	logic [17:0] w_stby;
	logic [17:0] w_prot;
	logic [17:0] w_loop;
	logic [17:0] w_src;

	assign w_gate  = shadow_ff[4'(`MCW_GATE_ALIGN - `MCW_FIRST_WORD)];
	assign w_cap   = shadow_ff[4'(`MCW_CAP_COMP - `MCW_FIRST_WORD)];
	assign w_shunt = shadow_ff[4'(`MCW_SHUNT_RATED - `MCW_FIRST_WORD)];
	assign w_stby  = shadow_ff[4'(`MCW_STANDBY_OFF - `MCW_FIRST_WORD)];
	assign w_prot  = shadow_ff[4'(`MCW_PROT_BRAKE - `MCW_FIRST_WORD)];
	assign w_loop  = shadow_ff[4'(`MCW_LOOP_SETPT - `MCW_FIRST_WORD)];
	assign w_src   = shadow_ff[4'(`MCW_SRC_INDUCT - `MCW_FIRST_WORD)];

	always_comb begin
		nxt_cfg = '0;
		nxt_cfg.gate_slew = w_gate[15:14];
		nxt_cfg.align_current_ma = 13'(w_gate[13:8] * `MCW_ALIGN_MA_PER_CNT);
		nxt_cfg.cap_comp_fall = w_cap[15:12];
		nxt_cfg.cap_comp_rise = w_cap[11:8];
		nxt_cfg.shunt_tenth_mohm =
			8'((w_shunt[15:8] * `MCW_SHUNT_TENTH_NUM) / `MCW_SHUNT_TENTH_DEN);
		// rated voltage in tenths of volt
		nxt_cfg.rated_tenth_v = 9'((w_shunt[7:0] * 10) / `MCW_RATED_DIV);
		nxt_cfg.sleep_inhibit = w_stby[15];
		nxt_cfg.nudge_start_amplitude =
			8'(w_stby[7:5] * `MCW_NUDGE_STEP + `MCW_NUDGE_BASE);
		nxt_cfg.short_detect_level =
			w_prot[15] ? 11'(`MCW_SHORT_HIGH_MV) : 11'(`MCW_SHORT_LOW_MV);
		nxt_cfg.lock_wait_s =
			w_prot[11] ? 4'(`MCW_LOCK_WAIT_LONG_S) : 4'(`MCW_LOCK_WAIT_SHORT_S);
		case (w_prot[7:6])
			2'h1:    nxt_cfg.stall_retry_limit = 4'(`MCW_RETRY_01);
			2'h2:    nxt_cfg.stall_retry_limit = 4'(`MCW_RETRY_10);
			2'h3:    nxt_cfg.stall_retry_limit = 4'(`MCW_RETRY_11);
			default: nxt_cfg.stall_retry_limit = 4'h0;
		endcase
		nxt_cfg.gentle_stop_long = w_prot[9];
		// ratio in quarter rpm per hertz
		nxt_cfg.clk_ratio = w_prot[5:0];
		nxt_cfg.loop_mode = mcw_loop_t'(w_loop[12:11]);
		nxt_cfg.winding_res =
			shadow_ff[4'(`MCW_WINDING_RES - `MCW_FIRST_WORD)][7:0];
		nxt_cfg.inductance = 15'({7'h00, w_src[7:0]} << w_src[10:8]);
		nxt_cfg.torque_constant_value =
			shadow_ff[4'(`MCW_TORQUE_CONST - `MCW_FIRST_WORD)][8:0];
		nxt_cfg.pi_primary   = shadow_ff[4'(`MCW_PI_PRIMARY - `MCW_FIRST_WORD)];
		nxt_cfg.pi_secondary =
			shadow_ff[4'(`MCW_PI_SECONDARY - `MCW_FIRST_WORD)][5:0];
	end

	// Run-time control from the demand and the curve
	logic [8:0]  curve_out;
	logic [8:0]  eff_dem;
	logic [8:0]  mag;
	logic [8:0]  off_lvl;
	logic [19:0] sp_prod;

	// corner lookup; corners assumed in ascending input order, no
	// interpolation between them to keep the path free of a divider
	always_comb begin
		curve_out = nv_ff[`MCW_CURVE_BASE][8:0];
		for (int i = 0; i < `MCW_CURVE_POINTS; i++) begin
			if (nv_ff[`MCW_CURVE_BASE + i][17:9] <= demand_in) begin
				curve_out = nv_ff[`MCW_CURVE_BASE + i][8:0];
			end
		end
	end

	always_comb begin
		eff_dem = w_loop[17] ? curve_out : demand_in;
		// two-way magnitude about the stop code
		if (w_loop[17] && w_loop[16]) begin
			if (eff_dem == 9'(`MCW_DEMAND_FULL)) begin
				// Doubling full forward would wrap past nine bits, so clamp it
				mag = 9'(`MCW_DEMAND_FULL);
			end else if (eff_dem > 9'(`MCW_DEMAND_STOP)) begin
				mag = 9'((eff_dem - 9'(`MCW_DEMAND_STOP)) << 1);
			end else begin
				mag = 9'((9'(`MCW_DEMAND_STOP) - eff_dem) << 1);
			end
		end else begin
			mag = eff_dem;
		end
		// off threshold scaled to demand units
		case (w_stby[9:8])
			2'h1:    off_lvl = 9'((`MCW_DEMAND_FULL * `MCW_OFF_PM_01) / 1000);
			2'h2:    off_lvl = 9'((`MCW_DEMAND_FULL * `MCW_OFF_PM_10) / 1000);
			2'h3:    off_lvl = 9'((`MCW_DEMAND_FULL * `MCW_OFF_PM_11) / 1000);
			default: off_lvl = 9'((`MCW_DEMAND_FULL * `MCW_OFF_PM_00) / 1000);
		endcase
		sp_prod = w_loop[10:0] * mag;
	end

	always_comb begin
		nxt_ctrl = '0;
		nxt_ctrl.curve_demand = eff_dem;
		nxt_ctrl.motor_stop = (mag < off_lvl);
		// setpoint equals full scale at full demand
		if (w_loop[12:11] != 2'h0) begin
			nxt_ctrl.setpoint = 11'(sp_prod / `MCW_DEMAND_FULL);
		end
		// brake source; safe or forced brake
		nxt_ctrl.brake_apply = (w_src[14] ? w_src[15] : brk_pin_ff) &&
			(w_prot[8] || current_safe);
		if (w_loop[17] && w_loop[16]) begin
			nxt_ctrl.dir_fwd = (eff_dem > 9'(`MCW_DEMAND_STOP));
		end else begin
			nxt_ctrl.dir_fwd = w_src[13] ? host_dir : dir_pin_ff;
		end
		nxt_ctrl.standby_enter = standby_req && !w_stby[15];
		// flag a ratio beyond the usable range
		nxt_ctrl.ratio_err = (w_prot[5:0] > 6'(`MCW_CLK_RATIO_MAX));
	end

	// Control results are held inert until the shadows are loaded
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_ff  <= '0;
			ctrl_ff <= '0;
		end else begin
			cfg_ff  <= nxt_cfg;
			ctrl_ff <= (state_ff == MCW_RUN) ? nxt_ctrl : '0;
		end
	end

	logic ready_ff;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= (state_ff == MCW_RUN);
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;
	assign cfg        = cfg_ff;
	assign ctrl       = ctrl_ff;
	assign cfg_ready  = ready_ff;
	assign ecc_err    = ecc_err_ff;

endmodule : mcw_bank

// ---- mcw_bank_sva.sv ----
/*
 * Port checker for the configuration word bank.
 * Assumes one clock, sys_clk, and the active-low asynchronous reset rstn.
 */
`timescale 1ns/1ns

module mcw_bank_sva
	import mcw_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	// Host register port
	input wire logic        reg_rd,
	input wire logic [23:0] reg_rdata,
	input wire logic        reg_rvalid,
	// Results
	input wire mcw_cfg_t    cfg,
	input wire mcw_ctrl_t   ctrl,
	input wire logic        cfg_ready,
	input wire logic        ecc_err
);
	logic [4:0] up_ff;
	logic [4:0] nxt_up;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Cycles since reset release, saturating
	always_comb begin
		nxt_up = up_ff;
		if (up_ff != 5'h1f) begin
			nxt_up = up_ff + 5'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			up_ff <= 5'h00;
		end else begin
			up_ff <= nxt_up;
		end
	end

	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe got no answer");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without a read strobe");
	a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 24'h000000)
		else $error("read data not zero outside an answer");
	a_check_hidden: assert property (reg_rvalid |-> reg_rdata[23:18] == 6'h00)
		else $error("check bits visible on read data");
	a_ready_hold: assert property (cfg_ready |=> cfg_ready)
		else $error("ready dropped after the copy");
	a_ready_early: assert property (cfg_ready |-> up_ff >= 5'h0e)
		else $error("ready before the copy walk could end");
	a_ready_late: assert property (up_ff == 5'h14 |-> cfg_ready)
		else $error("ready missing after the copy walk");
	a_ctrl_quiet: assert property (!cfg_ready |-> ctrl == '0)
		else $error("control active before shadows loaded");
	a_sleep_inhibit: assert property (cfg.sleep_inhibit |-> !ctrl.standby_enter)
		else $error("standby entered while inhibited");
	a_ratio_flag: assert property (cfg_ready |-> ctrl.ratio_err == (cfg.clk_ratio > 6'h29))
		else $error("ratio flag disagrees with ratio field");
	a_open_setpt: assert property (cfg_ready && cfg.loop_mode == MCW_OPEN_LOOP
		|-> ctrl.setpoint == 11'h000)
		else $error("setpoint nonzero in open loop");
	a_ecc_sticky: assert property (ecc_err |=> ecc_err)
		else $error("check error flag cleared without reset");

endmodule : mcw_bank_sva

bind mcw_bank mcw_bank_sva i_sva (
	.sys_clk    (sys_clk),
	.rstn       (rstn),
	.reg_rd     (reg_rd),
	.reg_rdata  (reg_rdata),
	.reg_rvalid (reg_rvalid),
	.cfg        (cfg),
	.ctrl       (ctrl),
	.cfg_ready  (cfg_ready),
	.ecc_err    (ecc_err)
);

// ---- mcw_host.sv ----
/*
 * Host model driving the register port of the word bank.
 * Assumes it is called from the bench on sys_clk, after cfg_ready is high.
 */
`timescale 1ns/1ns

module mcw_host (
	// Clock
	input  wire logic        sys_clk,
	// Register port
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [23:0] reg_wdata,
	input  wire logic [23:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	logic ratio_free;

	initial begin
		reg_addr = 8'hff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 24'hffffff;
		ratio_free = 1'b0;
	end

	// Upper bits set on purpose: the device must ignore them
	task automatic wr(input logic [7:0] a, input logic [17:0] d);
		logic [17:0] v;
		v = d;
		if (!ratio_free && a[5:0] == 6'h16 && d[5:0] > 6'h29) begin
			v[5:0] = 6'h29;
		end
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= {6'h3f, v};
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~{6'h3f, v};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge sys_clk);
		ok = reg_rvalid;
		d = reg_rdata;
	endtask : rd

endmodule : mcw_host

// ---- tb.sv ----
/*
 * Self-checking bench for the word bank: register access, field decode,
 * curve, thresholds and brake and direction selection.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/1ns

module tb
	import mcw_pkg::*;
;
	logic        sys_clk, rstn, brake_pin, dir_pin, host_dir, standby_req, current_safe;
	logic [8:0]  demand_in;
	logic [7:0]  reg_addr;
	logic        reg_wr, reg_rd, reg_rvalid, cfg_ready, ecc_err;
	logic [23:0] reg_wdata, reg_rdata;
	mcw_cfg_t    cfg;
	mcw_ctrl_t   ctrl;
	int          err_count, n_checks;

	mcw_bank i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .brake_pin(brake_pin), .dir_pin(dir_pin),
		.demand_in(demand_in), .host_dir(host_dir), .standby_req(standby_req),
		.current_safe(current_safe), .cfg(cfg), .ctrl(ctrl), .cfg_ready(cfg_ready),
		.ecc_err(ecc_err));
	mcw_host i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	always #2 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Pin synchronisers need about five cycles, so eight leaves margin
	task automatic settle();
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	task automatic sh(input logic [7:0] a, input logic [17:0] d);
		i_host.wr(a, d);
		settle();
	endtask : sh

	task automatic pins(input logic b, dr, h, s, sb, input logic [8:0] dm);
		@(posedge sys_clk);
		brake_pin <= b;
		dir_pin <= dr;
		host_dir <= h;
		current_safe <= s;
		standby_req <= sb;
		demand_in <= dm;
		settle();
	endtask : pins

	task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
		logic [23:0] d;
		logic        ok;
		i_host.rd(a, d, ok);
		chk(ok, 32'h1);
		chk(d, exp);
	endtask : rdchk

	task automatic t_reset();
		for (int i = 0; i < 40 && cfg_ready !== 1'b1; i++) @(negedge sys_clk);
		chk(cfg_ready, 32'h1);
		chk(cfg.short_detect_level, 32'h3e8);
		chk(cfg.lock_wait_s, 32'h5);
		rdchk(8'h12, 24'h000000);
	endtask : t_reset

	task automatic t_words();
		for (int a = 8'h12; a < 8'h40; a++) i_host.wr(8'(a), {a[5:0], 12'hc25});
		for (int a = 8'h12; a < 8'h40; a++) begin
			rdchk(8'(a), (a == 8'h1b || a >= 8'h1e && a <= 8'h1f) ? 24'h0 :
				{6'h00, a[5:0], 12'hc25});
		end
		rdchk(8'h05, 24'h000000);
		rdchk(8'h7f, 24'h000000);
		chk(cfg.rated_tenth_v, 32'h0);
	endtask : t_words

	task automatic t_fields();
		logic [3:0] rt [4] = '{4'h0, 4'h3, 4'h5, 4'ha};
		sh(8'h52, 18'h0bf00);
		chk(cfg.gate_slew, 32'h2);
		chk(cfg.align_current_ma, 32'h152a);
		rdchk(8'h52, 24'h00bf00);
		sh(8'h54, {2'b00, 8'h4a, 8'hc8});
		chk(cfg.shunt_tenth_mohm, 32'h14);
		chk(cfg.rated_tenth_v, 32'h190);
		sh(8'h55, 18'h080e0);
		chk(cfg.nudge_start_amplitude, 32'hf8);
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 9'h1ff);
		chk(ctrl.standby_enter, 32'h0);
		sh(8'h55, 18'h00000);
		chk(ctrl.standby_enter, 32'h1);
		sh(8'h56, 18'h08ae9);
		chk(cfg.short_detect_level, 32'h7d0);
		chk(cfg.lock_wait_s, 32'ha);
		chk(cfg.gentle_stop_long, 32'h1);
		chk(ctrl.ratio_err, 32'h0);
		for (int c = 0; c < 4; c++) begin
			sh(8'h56, {10'h000, 2'(c), 6'h00});
			chk(cfg.stall_retry_limit, rt[c]);
		end
		i_host.ratio_free = 1'b1;
		sh(8'h56, 18'h0002a);
		chk(ctrl.ratio_err, 32'h1);
		i_host.ratio_free = 1'b0;
		sh(8'h53, 18'h0a500);
		chk({cfg.cap_comp_fall, cfg.cap_comp_rise}, 32'ha5);
		sh(8'h58, 18'h000c3);
		chk(cfg.winding_res, 32'hc3);
		sh(8'h59, 18'h005ff);
		chk(cfg.inductance, 32'h1fe0);
		sh(8'h5a, 18'h001ab);
		chk(cfg.torque_constant_value, 32'h1ab);
		sh(8'h5c, 18'h2a5a5);
		sh(8'h5d, 18'h0002d);
		chk({cfg.pi_primary, cfg.pi_secondary}, {8'h00, 18'h2a5a5, 6'h2d});
	endtask : t_fields

	task automatic t_loop_off();
		logic [8:0] th [4] = '{9'h031, 9'h01d, 9'h041, 9'h063};
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h1ff);
		for (int c = 0; c < 4; c++) begin
			sh(8'h57, {5'h00, 2'(c), 11'h5a5});
			chk(cfg.loop_mode, c);
			chk(ctrl.setpoint, c == 0 ? 32'h0 : 32'h5a5);
		end
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h0ff);
		chk(ctrl.setpoint, 32'h5a5 * 32'hff / 32'h1ff);
		for (int c = 0; c < 4; c++) begin
			sh(8'h55, {8'h00, 2'(c), 8'h00});
			pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, th[c] - 9'h001);
			chk(ctrl.motor_stop, 32'h1);
			pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, th[c]);
			chk(ctrl.motor_stop, 32'h0);
		end
	endtask : t_loop_off

	task automatic t_curve();
		for (int i = 0; i < 32; i++) i_host.wr(8'(8'h20 + i), {9'(i * 16), 9'(511 - i * 16)});
		rdchk(8'h26, {6'h00, 9'h060, 9'h19f});
		sh(8'h57, 18'h217ff);
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h064);
		chk(ctrl.setpoint, 32'h7ff * 32'h19f / 32'h1ff);
		chk(ctrl.curve_demand, 32'h19f);
		sh(8'h57, 18'h317ff);
		chk(ctrl.setpoint, 32'h7ff * 32'h140 / 32'h1ff);
		chk(ctrl.dir_fwd, 32'h1);
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h190);
		chk(ctrl.setpoint, 32'h7ff * 32'h120 / 32'h1ff);
		chk(ctrl.dir_fwd, 32'h0);
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h000);
		chk(ctrl.curve_demand, 32'h1ff);
		chk(ctrl.setpoint, 32'h7ff);
		chk(ctrl.dir_fwd, 32'h1);
		sh(8'h57, 18'h217ff);
		pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h1f0);
		chk(ctrl.motor_stop, 32'h1);
	endtask : t_curve

	task automatic t_brake_dir();
		sh(8'h57, 18'h00000);
		sh(8'h59, 18'h0c000);
		sh(8'h56, 18'h00000);
		chk(ctrl.brake_apply, 32'h0);
		pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 9'h1ff);
		chk(ctrl.brake_apply, 32'h1);
		sh(8'h56, 18'h00100);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h1ff);
		chk(ctrl.brake_apply, 32'h1);
		sh(8'h59, 18'h04000);
		chk(ctrl.brake_apply, 32'h0);
		sh(8'h59, 18'h00000);
		chk(ctrl.brake_apply, 32'h1);
		pins(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 9'h1ff);
		chk(ctrl.brake_apply, 32'h0);
		sh(8'h59, 18'h02000);
		chk(ctrl.dir_fwd, 32'h1);
		pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 9'h1ff);
		chk(ctrl.dir_fwd, 32'h0);
		sh(8'h59, 18'h00000);
		chk(ctrl.dir_fwd, 32'h1);
		chk(ecc_err, 32'h0);
	endtask : t_brake_dir

	task automatic results();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	initial begin
		{sys_clk, rstn, brake_pin, dir_pin, host_dir, standby_req, current_safe} = 7'h00;
		demand_in = 9'h000;
		err_count = 0;
		n_checks = 0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_words();
		t_fields();
		t_loop_off();
		t_curve();
		t_brake_dir();
		results();
	end

	// The tests need under ten thousand cycles
	initial begin
		#100000;
		err_count++;
		results();
	end

endmodule : tb
